/* inc/rlc_regs.vh */
`ifndef RLC_REGS_VH
`define RLC_REGS_VH

// Register offsets on the management bus
`define RLC_OFF_SWING 8'h3B
`define RLC_OFF_DEEMPH 8'h3C
`define RLC_OFF_THRESH 8'h3D
`define RLC_OFF_SPARE_3E 8'h3E
`define RLC_OFF_SPARE_3F 8'h3F
`define RLC_OFF_IDLE 8'h40
`define RLC_OFF_EQ 8'h41

// Reset values
`define RLC_RST_SWING 8'hAD
`define RLC_RST_DEEMPH 5'h02
`define RLC_RST_THRESH 8'h00
`define RLC_RST_SPARE 8'h00
`define RLC_RST_IDLE 8'h00
`define RLC_RST_EQ 8'h2F

// Field positions
`define RLC_SWING_SCP_BIT 7
`define RLC_SWING_RATE_BIT 6
`define RLC_SWING_FIXED 5:3
`define RLC_SWING_CODE 2:0
`define RLC_DEEMPH_FAR_RECEIVER_PROBE_MODE_BIT 7
`define RLC_DEEMPH_RATE 6:5
`define RLC_DEEMPH_STORED 4:0
`define RLC_DEEMPH_CODE 2:0
`define RLC_THR_ASSERT 3:2
`define RLC_THR_DEASSERT 1:0
`define RLC_IDLE_MANUAL_BIT 5
`define RLC_IDLE_MUTE_BIT 4
`define RLC_IDLE_PROBE 3:2

// Receiver probe modes
`define RLC_PROBE_HIZ 2'b00
`define RLC_PROBE_LIMITED 2'b01
`define RLC_PROBE_ENDLESS 2'b10
`define RLC_PROBE_TERM 2'b11

// Timing
`define RLC_CLK_KHZ 50000
`define RLC_PROBE_MS 12
`define RLC_PROBE_TRIES 6'd50
// 12 ms of 50 MHz clock cycles
`define RLC_PROBE_CYCLES 24'h0927C0

`endif

/* rtl/rlc_sync2.v */
`timescale 1ns/1ps

module rlc_sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // Clock and reset
   input wire sys_clk,
   input wire resetn,
   // Asynchronous levels in, synchronised levels out
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;

   always @(posedge sys_clk) begin
      if (!resetn) begin
         meta_q <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // rlc_sync2

/* rtl/rlc_far_receiver_probe_mode.v */
`timescale 1ns/1ps
`include "rlc_regs.vh"

module rlc_far_receiver_probe_mode #(
   parameter [23:0] PERIOD = 24'd600000
) (
   // Clock and reset
   input wire sys_clk,
   input wire resetn,
   // Control and probe result
   input wire [1:0] probe_mode,
   input wire rx_present,
   // Lane controls
   output reg term_50ohm,
   output reg probe_pulse
);

   localparam [23:0] LAST = PERIOD - 24'h000001;

   reg [1:0] mode_q;
   reg [23:0] tick_q;
   reg [5:0] tries_q;
   reg found_q;
   wire limited_w;
   wire probing_w;

   assign limited_w = (probe_mode == `RLC_PROBE_LIMITED);
   assign probing_w = !found_q && ((limited_w && tries_q < `RLC_PROBE_TRIES) ||
                                   (probe_mode == `RLC_PROBE_ENDLESS));

   always @(posedge sys_clk) begin
      if (!resetn) begin
         mode_q <= `RLC_PROBE_HIZ;
         tick_q <= 24'h000000;
         tries_q <= 6'h00;
         found_q <= 1'b0;
         probe_pulse <= 1'b0;
         term_50ohm <= 1'b0;
      end else begin
         mode_q <= probe_mode;
         probe_pulse <= 1'b0;
         // A mode change restarts the search from scratch
         if (probe_mode != mode_q) begin
            tick_q <= 24'h000000;
            tries_q <= 6'h00;
            found_q <= 1'b0;
         end else if (probing_w) begin
            if (rx_present) begin
               found_q <= 1'b1;
            end
            if (tick_q == LAST) begin
               tick_q <= 24'h000000;
               probe_pulse <= 1'b1;
               if (limited_w) begin
                  tries_q <= tries_q + 6'h01;
               end
            end else begin
               tick_q <= tick_q + 24'h000001;
            end
         end
         term_50ohm <= (probe_mode == `RLC_PROBE_TERM) ||
                       (probe_mode != `RLC_PROBE_HIZ && found_q);
      end
   end

endmodule // rlc_far_receiver_probe_mode

/* rtl/rlc_lane_regs.v */
`timescale 1ns/1ps
`include "rlc_regs.vh"

// Behaviour
// - Registers reachable as bus target, byte-wide
// - Swing bit 7 enables short-circuit protection
// - Swing bit 6 overrides rate pin
// - Swing code 2:0 selects 0.7-1.4 V
// - De-emphasis bit 7 reports receiver detected
// - De-emphasis bits 6:5 report detected rate
// - De-emphasis code 2:0 selects 0 to -12 dB
// - Assert threshold code in bits 3:2
// - Deassert threshold code in bits 1:0
// - Register thresholds override threshold pin
// - Bit 5 picks manual over automatic idle
// - Manual bit 4 mutes lane output
// - Probe mode 00 hi-Z, 11 fixed 50 ohm
// - Mode 01 probes every 12 ms, 50 tries
// - Mode 10 probes every 12 ms endlessly
// - Register probe mode overrides probe pin
// - Equalizer byte, 256 levels, reset 0x2F
module rlc_lane_regs #(
   parameter [6:0] TARGET_ADDR = 7'h5A,
   parameter [23:0] PROBE_CYCLES = `RLC_PROBE_CYCLES
) (
   // Clock and reset
   input wire sys_clk,
   input wire resetn,
   // Management bus pins
   input wire scl,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe,
   // Lane 6 live state from the analogue path
   input wire lane6_rx_detected,
   input wire [1:0] lane6_detected_link_rate,
   // Lane 7 live state from the analogue path
   input wire lane7_rx_present,
   input wire lane7_auto_idle,
   // Lane 6 controls
   output wire lane6_short_protect_en,
   output wire lane6_rate_gen12,
   output wire [2:0] lane6_output_swing,
   output wire [2:0] lane6_deemphasis_level,
   output wire [1:0] lane6_idle_assert_sel,
   output wire [1:0] lane6_idle_deassert_sel,
   // Lane 7 controls
   output reg lane7_mute,
   output wire lane7_term_50ohm,
   output wire lane7_probe_pulse,
   output wire [7:0] lane7_eq_level
);

   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_CMD = 4'h2;
   localparam [3:0] ST_WDAT = 4'h3;
   localparam [3:0] ST_ACK = 4'h4;
   localparam [3:0] ST_RDAT = 4'h5;
   localparam [3:0] ST_RWAIT = 4'h6;
   localparam [3:0] ST_RACK = 4'h7;
   localparam [3:0] ST_RLOAD = 4'h8;

   // Register storage
   reg [7:0] swing_q;
   reg [4:0] deemph_q;
   reg [7:0] thresh_q;
   reg [7:0] spare_3e_q;
   reg [7:0] spare_3f_q;
   reg [7:0] idle_q;
   reg [7:0] eq_q;

   // Bus engine state
   reg [3:0] st_q;
   reg [3:0] nxt_q;
   reg [2:0] bit_q;
   reg [7:0] sh_q;
   reg [7:0] ptr_q;
   reg ack_pend_q;
   reg scl_prev_q;
   reg sda_prev_q;
   reg wr_stb_q;
   reg [7:0] wr_ptr_q;
   reg [7:0] wr_dat_q;

   wire [6:0] sync_w;
   wire scl_s;
   wire sda_s;
   wire l6_det_s;
   wire [1:0] l6_rate_s;
   wire l7_present_s;
   wire l7_idle_s;
   wire scl_rise_w;
   wire scl_fall_w;
   wire start_w;
   wire stop_w;
   wire [7:0] rx_byte_w;
   wire [7:0] rd_w;

   // Read view of one register; status bits come live from the lane
   function [7:0] rd_byte;
      input [7:0] a;
      begin
         case (a)
            `RLC_OFF_SWING: rd_byte = swing_q;
            `RLC_OFF_DEEMPH: rd_byte = {l6_det_s, l6_rate_s, deemph_q};
            `RLC_OFF_THRESH: rd_byte = thresh_q;
            `RLC_OFF_SPARE_3E: rd_byte = spare_3e_q;
            `RLC_OFF_SPARE_3F: rd_byte = spare_3f_q;
            `RLC_OFF_IDLE: rd_byte = idle_q;
            `RLC_OFF_EQ: rd_byte = eq_q;
            default: rd_byte = 8'h00;
         endcase
      end
   endfunction

   // Every pin and analogue level is asynchronous to sys_clk.
   // The two rate bits may tear for one cycle on a change; software
   // should re-read if it sees the unused code 10.
   // Bus pins rest high, so the synced copies leave reset with no false edge
   rlc_sync2 #(
      .WIDTH(7),
      .RST_VAL(7'h60)
   ) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in({scl, sda_i, lane6_rx_detected, lane6_detected_link_rate,
                 lane7_rx_present, lane7_auto_idle}),
      .sync_out(sync_w)
   );

   assign scl_s = sync_w[6];
   assign sda_s = sync_w[5];
   assign l6_det_s = sync_w[4];
   assign l6_rate_s = sync_w[3:2];
   assign l7_present_s = sync_w[1];
   assign l7_idle_s = sync_w[0];

   assign scl_rise_w = scl_s && !scl_prev_q;
   assign scl_fall_w = !scl_s && scl_prev_q;
   assign start_w = scl_s && scl_prev_q && sda_prev_q && !sda_s;
   assign stop_w = scl_s && scl_prev_q && !sda_prev_q && sda_s;
   assign rx_byte_w = {sh_q[6:0], sda_s};
   assign rd_w = rd_byte(ptr_q);

   always @(posedge sys_clk) begin
      if (!resetn) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // Bus target: bits sampled on SCL rise, SDA changed on SCL fall
   always @(posedge sys_clk) begin
      if (!resetn) begin
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         ack_pend_q <= 1'b0;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
         wr_stb_q <= 1'b0;
         wr_ptr_q <= 8'h00;
         wr_dat_q <= 8'h00;
      end else begin
         sda_o <= 1'b0;
         wr_stb_q <= 1'b0;
         if (start_w) begin
            st_q <= ST_ADDR;
            bit_q <= 3'h0;
            ack_pend_q <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_w) begin
            st_q <= ST_IDLE;
            ack_pend_q <= 1'b0;
            sda_oe <= 1'b0;
         end else if (scl_rise_w) begin
            case (st_q)
               ST_ADDR, ST_CMD, ST_WDAT: begin
                  sh_q <= rx_byte_w;
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     if (st_q == ST_ADDR) begin
                        if (rx_byte_w[7:1] == TARGET_ADDR) begin
                           ack_pend_q <= 1'b1;
                           nxt_q <= rx_byte_w[0] ? ST_RDAT : ST_CMD;
                        end else begin
                           st_q <= ST_IDLE;
                        end
                     end else if (st_q == ST_CMD) begin
                        ptr_q <= rx_byte_w;
                        ack_pend_q <= 1'b1;
                        nxt_q <= ST_WDAT;
                     end else begin
                        wr_stb_q <= 1'b1;
                        wr_ptr_q <= ptr_q;
                        wr_dat_q <= rx_byte_w;
                        ptr_q <= ptr_q + 8'h01;
                        ack_pend_q <= 1'b1;
                        nxt_q <= ST_WDAT;
                     end
                  end
               end
               ST_RDAT: begin
                  sh_q <= {sh_q[6:0], 1'b0};
                  bit_q <= bit_q + 3'h1;
                  if (bit_q == 3'h7) begin
                     st_q <= ST_RWAIT;
                  end
               end
               ST_RACK: begin
                  // Host acknowledge asks for the next byte
                  if (!sda_s) begin
                     ptr_q <= ptr_q + 8'h01;
                     st_q <= ST_RLOAD;
                  end else begin
                     st_q <= ST_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall_w) begin
            if (ack_pend_q) begin
               ack_pend_q <= 1'b0;
               sda_oe <= 1'b1;
               st_q <= ST_ACK;
            end else begin
               case (st_q)
                  ST_ACK: begin
                     bit_q <= 3'h0;
                     st_q <= nxt_q;
                     if (nxt_q == ST_RDAT) begin
                        sh_q <= rd_w;
                        sda_oe <= !rd_w[7];
                     end else begin
                        sda_oe <= 1'b0;
                     end
                  end
                  ST_RLOAD: begin
                     bit_q <= 3'h0;
                     sh_q <= rd_w;
                     sda_oe <= !rd_w[7];
                     st_q <= ST_RDAT;
                  end
                  ST_RDAT: begin
                     sda_oe <= !sh_q[7];
                  end
                  ST_RWAIT: begin
                     sda_oe <= 1'b0;
                     st_q <= ST_RACK;
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // Register file
   always @(posedge sys_clk) begin
      if (!resetn) begin
         swing_q <= `RLC_RST_SWING;
         deemph_q <= `RLC_RST_DEEMPH;
         thresh_q <= `RLC_RST_THRESH;
         spare_3e_q <= `RLC_RST_SPARE;
         spare_3f_q <= `RLC_RST_SPARE;
         idle_q <= `RLC_RST_IDLE;
         eq_q <= `RLC_RST_EQ;
      end else if (wr_stb_q) begin
         case (wr_ptr_q)
            `RLC_OFF_SWING: swing_q <= wr_dat_q;
            `RLC_OFF_DEEMPH: deemph_q <= wr_dat_q[`RLC_DEEMPH_STORED];
            `RLC_OFF_THRESH: thresh_q <= wr_dat_q;
            `RLC_OFF_SPARE_3E: spare_3e_q <= wr_dat_q;
            `RLC_OFF_SPARE_3F: spare_3f_q <= wr_dat_q;
            `RLC_OFF_IDLE: idle_q <= wr_dat_q;
            `RLC_OFF_EQ: eq_q <= wr_dat_q;
            default: begin
            end
         endcase
      end
   end

   assign lane6_short_protect_en = swing_q[`RLC_SWING_SCP_BIT];
   assign lane6_rate_gen12 = swing_q[`RLC_SWING_RATE_BIT];
   assign lane6_output_swing = swing_q[`RLC_SWING_CODE];
   assign lane6_deemphasis_level = deemph_q[`RLC_DEEMPH_CODE];
   assign lane6_idle_assert_sel = thresh_q[`RLC_THR_ASSERT];
   assign lane6_idle_deassert_sel = thresh_q[`RLC_THR_DEASSERT];
   assign lane7_eq_level = eq_q;

   // Lane 7 electrical idle
   always @(posedge sys_clk) begin
      if (!resetn) begin
         lane7_mute <= 1'b0;
      end else begin
         lane7_mute <= idle_q[`RLC_IDLE_MANUAL_BIT] ? idle_q[`RLC_IDLE_MUTE_BIT] : l7_idle_s;
      end
   end

   rlc_far_receiver_probe_mode #(
      .PERIOD(PROBE_CYCLES)
   ) u_far_receiver_probe_mode (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .probe_mode(idle_q[`RLC_IDLE_PROBE]),
      .rx_present(l7_present_s),
      .term_50ohm(lane7_term_50ohm),
      .probe_pulse(lane7_probe_pulse)
   );

endmodule // rlc_lane_regs

/* bench/rlc_lane_regs_checker.sv */
`timescale 1ns/1ps
module rlc_lane_regs_checker #(
   parameter [6:0] TARGET_ADDR = 7'h5A,
   parameter [23:0] PROBE_CYCLES = 24'd600000
) (
   // Clock and reset
   input wire sys_clk,
   input wire resetn,
   // Bus pins
   input wire scl,
   input wire sda_o,
   input wire sda_oe,
   // Lane outputs
   input wire lane6_short_protect_en,
   input wire lane6_rate_gen12,
   input wire [2:0] lane6_output_swing,
   input wire [2:0] lane6_deemphasis_level,
   input wire [1:0] lane6_idle_assert_sel,
   input wire [1:0] lane6_idle_deassert_sel,
   input wire lane7_term_50ohm,
   input wire lane7_probe_pulse,
   input wire [7:0] lane7_eq_level
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   a_sda_open_drain:
   assert property (sda_o == 1'h0) else $error("sda_o high");
   // SDA may only move while SCL is low, or it would fake a start or stop
   a_oe_scl_low:
   assert property ($changed(sda_oe) |-> !scl) else $error("sda_oe moved with scl high");
   a_oe_hold_high:
   assert property ($rose(scl) |=> $stable(sda_oe) [*8]) else $error("sda_oe unstable");
   // Updates land within a few cycles of an SCL rise, never later
   a_swing_quiet:
   assert property (scl [*8] ##1 scl [*2] |-> $stable({lane6_short_protect_en, lane6_rate_gen12,
      lane6_output_swing})) else $error("swing changed late");
   a_deemph_quiet:
   assert property (scl [*8] ##1 scl [*2] |-> $stable(lane6_deemphasis_level)) else $error("deemph changed late");
   a_thresh_quiet:
   assert property (scl [*8] ##1 scl [*2] |-> $stable({lane6_idle_assert_sel, lane6_idle_deassert_sel}))
      else $error("threshold changed late");
   a_eq_quiet:
   assert property (!scl [*8] |-> $stable(lane7_eq_level)) else $error("eq changed with scl low");
   a_probe_one_cycle:
   assert property (lane7_probe_pulse |=> !lane7_probe_pulse [*8]) else $error("probe pulse too long");
   a_term_no_probe:
   assert property (lane7_term_50ohm |-> !lane7_probe_pulse) else $error("probe while terminated");
endmodule // rlc_lane_regs_checker

/* bench/rlc_smbus_host.sv */
`timescale 1ns/1ps
module rlc_smbus_host #(
   parameter [6:0] ADDR = 7'h5A
) (
   // Clock
   input wire sys_clk,
   // Bus wires
   input wire sda_oe,
   output reg scl,
   output wire sda_w
);
   reg lo = 1'h0;
   // Pull-up wire, low if either side pulls
   assign sda_w = !(lo || sda_oe);
   initial scl = 1'h1;
   task hw(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   // data set while SCL low, sampled mid-high
   task bit_io(input b, output r);
      begin
         lo <= !b;
         hw(10);
         scl <= 1'h1;
         hw(5);
         r = sda_w;
         hw(5);
         scl <= 1'h0;
         hw(2);
      end
   endtask
   task byte_io(input [7:0] d, input ack_in, output [7:0] q, output ack);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(d[i], r);
            q[i] = r;
         end
         bit_io(ack_in, ack);
      end
   endtask
   task bus_start;
      begin
         lo <= 1'h1;
         hw(10);
         scl <= 1'h0;
         hw(2);
      end
   endtask
   task bus_stop;
      begin
         lo <= 1'h1;
         hw(10);
         scl <= 1'h1;
         hw(10);
         lo <= 1'h0;
         hw(10);
      end
   endtask
   task wr(input [6:0] a, input [7:0] off, input [7:0] d, output nack);
      reg [7:0] q;
      reg k1, k2, k3;
      begin
         bus_start;
         byte_io({a, 1'h0}, 1'h1, q, k1);
         byte_io(off, 1'h1, q, k2);
         byte_io(d, 1'h1, q, k3);
         bus_stop;
         nack = k1 | k2 | k3;
      end
   endtask
   task rd(input [7:0] off, output [7:0] d);
      reg [7:0] q;
      reg k;
      begin
         bus_start;
         byte_io({ADDR, 1'h0}, 1'h1, q, k);
         byte_io(off, 1'h1, q, k);
         lo <= 1'h0;
         hw(10);
         scl <= 1'h1;
         hw(10);
         bus_start;
         byte_io({ADDR, 1'h1}, 1'h1, q, k);
         byte_io(8'hFF, 1'h1, d, k);
         bus_stop;
      end
   endtask
endmodule // rlc_smbus_host

/* bench/rlc_lane_regs_tb.sv */
`timescale 1ns/1ps
module rlc_lane_regs_tb;
   localparam [6:0] ADDR = 7'h5A;
   localparam [7:0] RST_V [0:6] = '{8'hAD, 8'hE2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2F};
   reg sys_clk = 1'h0;
   reg resetn = 1'h0;
   reg lane6_rx_detected = 1'h1;
   reg [1:0] lane6_detected_link_rate = 2'h3;
   reg lane7_rx_present = 1'h0;
   reg lane7_auto_idle = 1'h0;
   wire scl, sda_w, sda_o, sda_oe, scp, gen12, mute, term, pulse;
   wire [2:0] swing, deemph;
   wire [1:0] thr_a, thr_d;
   wire [7:0] eq;
   integer error_cnt = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer i;
   reg [7:0] pulse_cnt = 8'h00;
   reg [7:0] p0;
   reg [7:0] v;
   reg nk;

   always #10 sys_clk = ~sys_clk;

   rlc_lane_regs #(.TARGET_ADDR(ADDR), .PROBE_CYCLES(24'h14)) DUT (
      .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .lane6_rx_detected(lane6_rx_detected), .lane6_detected_link_rate(lane6_detected_link_rate),
      .lane7_rx_present(lane7_rx_present), .lane7_auto_idle(lane7_auto_idle),
      .lane6_short_protect_en(scp), .lane6_rate_gen12(gen12), .lane6_output_swing(swing),
      .lane6_deemphasis_level(deemph), .lane6_idle_assert_sel(thr_a), .lane6_idle_deassert_sel(thr_d),
      .lane7_mute(mute), .lane7_term_50ohm(term), .lane7_probe_pulse(pulse), .lane7_eq_level(eq)
   );
   rlc_smbus_host #(.ADDR(ADDR)) host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda_w(sda_w));

   task conclude;
      begin
         $display("checks %0d errors %0d", n_checks, error_cnt);
         if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] g, input [7:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task rchk(input [7:0] off, input [7:0] e);
      begin
         host.rd(off, v);
         chk($sformatf("reg %h", off), v, e);
      end
   endtask
   task wr(input [7:0] off, input [7:0] d);
      begin
         host.wr(ADDR, off, d, nk);
         chk("ack", {7'h00, nk}, 8'h00);
         repeat (10) @(posedge sys_clk);
      end
   endtask

   // Hang guard: the sequence needs roughly 21000 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (pulse)
         pulse_cnt <= pulse_cnt + 8'h01;
      if (cyc == 60000) begin
         error_cnt = error_cnt + 1;
         conclude;
      end
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'h1;
      repeat (5) @(posedge sys_clk);
      for (i = 0; i < 7; i = i + 1)
         rchk(8'h3B + i[7:0], RST_V[i]);
      chk("lane6", {scp, gen12, swing, deemph}, 8'hAA);
      chk("thr", {4'h0, thr_a, thr_d}, 8'h00);
      chk("eq", eq, 8'h2F);
      wr(8'h3B, 8'h6F);
      rchk(8'h3B, 8'h6F);
      chk("lane6", {scp, gen12, swing, deemph}, 8'h7A);
      lane6_rx_detected <= 1'h0;
      lane6_detected_link_rate <= 2'h1;
      wr(8'h3C, 8'hE5);
      rchk(8'h3C, 8'h25);
      chk("lane6", {scp, gen12, swing, deemph}, 8'h7D);
      lane6_rx_detected <= 1'h1;
      lane6_detected_link_rate <= 2'h0;
      rchk(8'h3C, 8'h85);
      wr(8'h3D, 8'h0E);
      chk("thr", {4'h0, thr_a, thr_d}, 8'h0E);
      wr(8'h41, 8'hFF);
      rchk(8'h41, 8'hFF);
      host.wr(ADDR ^ 7'h01, 8'h41, 8'h00, nk);
      chk("nack", {7'h00, nk}, 8'h01);
      chk("eq", eq, 8'hFF);
      rchk(8'h50, 8'h00);
      wr(8'h40, 8'h30);
      chk("mute", {7'h00, mute}, 8'h01);
      lane7_auto_idle <= 1'h1;
      wr(8'h40, 8'h20);
      chk("mute", {7'h00, mute}, 8'h00);
      wr(8'h40, 8'h00);
      chk("mute", {7'h00, mute}, 8'h01);
      wr(8'h40, 8'h0C);
      chk("term", {7'h00, term}, 8'h01);
      p0 = pulse_cnt;
      wr(8'h40, 8'h00);
      repeat (100) @(posedge sys_clk);
      chk("term", {7'h00, term}, 8'h00);
      chk("pulses", pulse_cnt - p0, 8'h00);
      p0 = pulse_cnt;
      wr(8'h40, 8'h04);
      repeat (1200) @(posedge sys_clk);
      chk("pulses", pulse_cnt - p0, 8'h32);
      chk("term", {7'h00, term}, 8'h00);
      p0 = pulse_cnt;
      wr(8'h40, 8'h08);
      repeat (1200) @(posedge sys_clk);
      chk("endless", {7'h00, pulse_cnt - p0 > 8'h32}, 8'h01);
      lane7_rx_present <= 1'h1;
      repeat (10) @(posedge sys_clk);
      chk("term", {7'h00, term}, 8'h01);
      p0 = pulse_cnt;
      repeat (100) @(posedge sys_clk);
      chk("pulses", pulse_cnt - p0, 8'h00);
      resetn <= 1'h0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'h1;
      repeat (5) @(posedge sys_clk);
      chk("lane6", {scp, gen12, swing, deemph}, 8'hAA);
      chk("eq", eq, 8'h2F);
      conclude;
   end
endmodule // rlc_lane_regs_tb

bind rlc_lane_regs rlc_lane_regs_checker #(.TARGET_ADDR(TARGET_ADDR), .PROBE_CYCLES(PROBE_CYCLES)) u_chk (
   .sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_o(sda_o), .sda_oe(sda_oe),
   .lane6_short_protect_en(lane6_short_protect_en), .lane6_rate_gen12(lane6_rate_gen12),
   .lane6_output_swing(lane6_output_swing), .lane6_deemphasis_level(lane6_deemphasis_level),
   .lane6_idle_assert_sel(lane6_idle_assert_sel), .lane6_idle_deassert_sel(lane6_idle_deassert_sel),
   .lane7_term_50ohm(lane7_term_50ohm), .lane7_probe_pulse(lane7_probe_pulse), .lane7_eq_level(lane7_eq_level)
);
